// file: inc/sfw_mod_if.sv
// Link between the frequency sequencer and its delta-sigma modulator.
// Assumes both ends run on clk_sys.
`timescale 1ns/1ns
interface sfw_mod_if;
  logic [6:0] intRatio;
  logic [15:0] fracWord;
  logic [7:0] divRatio;
  modport ctrl (output intRatio, output fracWord, input divRatio);
  modport dsm (input intRatio, input fracWord, output divRatio);
endinterface

// file: inc/sfw_pkg.sv
// Shared constants and types of the synthesizer frequency-word control.
// Assumes a 250 MHz system clock and register access decoded by the serial port.
package sfw_pkg;

  // Clock and reference
  localparam int CLK_MHZ = 250;
  localparam int REF_MHZ = 10;
  localparam int CLK_PERIOD_NS = 1000 / CLK_MHZ;
  localparam int REF_TICK_CYCLES = CLK_MHZ / REF_MHZ;

  // Tuning phase times in ns and their cycle counts
  localparam int BIAS_SETTLE_NS = 20000;
  localparam int VCO_CAL_NS = 80000;
  localparam int LOOP_SETTLE_NS = 100000;
  localparam int TUNE_TOTAL_NS = 200000;
  localparam int BIAS_SETTLE_CYCLES = (BIAS_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int VCO_CAL_CYCLES = (VCO_CAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOOP_SETTLE_CYCLES = (LOOP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TUNE_TOTAL_CYCLES = TUNE_TOTAL_NS / CLK_PERIOD_NS;

  // Register offsets
  localparam logic [6:0] ADDR_OFFSET_LOW = 7'h73;
  localparam logic [6:0] ADDR_OFFSET_HIGH = 7'h74;
  localparam logic [6:0] ADDR_BAND_SELECT = 7'h75;
  localparam logic [6:0] ADDR_CARRIER_HIGH = 7'h76;
  localparam logic [6:0] ADDR_CARRIER_LOW = 7'h77;
  localparam logic [6:0] ADDR_HOP_CHANNEL = 7'h79;
  localparam logic [6:0] ADDR_HOP_STEP = 7'h7A;

  // Reset values
  localparam logic [7:0] RST_OFFSET_LOW = 8'h00;
  localparam logic [7:0] RST_OFFSET_HIGH = 8'h00;
  localparam logic [7:0] RST_BAND_SELECT = 8'h35;
  localparam logic [7:0] RST_CARRIER_HIGH = 8'hBB;
  localparam logic [7:0] RST_CARRIER_LOW = 8'h80;
  localparam logic [7:0] RST_HOP_CHANNEL = 8'h00;
  localparam logic [7:0] RST_HOP_STEP = 8'h00;

  // Field positions
  localparam int BAND_SB_BIT = 6;
  localparam int BAND_HB_BIT = 5;
  localparam int BAND_INDEX_MSB = 4;
  localparam int OFFSET_HIGH_MSB = 1;

  // Arithmetic of the division ratio; one fractional unit is 10 MHz / 64000
  localparam logic [4:0] BAND_INDEX_MAX = 5'h17;
  localparam logic [6:0] INT_RATIO_BASE = 7'h18;
  localparam logic [16:0] FRAC_MODULUS = 17'h0_FA00;
  localparam logic [15:0] IF_SHIFT_UNITS = 16'h1770;
  localparam int HOP_UNIT_SHIFT = 6;
  localparam int DEV_UNIT_SHIFT = 2;

  typedef enum logic [1:0] {
    MODE_READY = 2'h0,
    MODE_TUNE = 2'h1,
    MODE_TX = 2'h2,
    MODE_RX = 2'h3
  } sfw_mode_t;

endpackage

// file: verif/sfw_host_model.sv
// Host side of the register port: byte writes and reads, one request at a time.
// Assumes the block samples the strobes on the rising edge of clk_sys.
`timescale 1ns/1ns
module sfw_host_model (
  input wire logic clk_sys,
  output logic regWrEn,
  output logic regRdEn,
  output logic [6:0] regAddr,
  output logic [7:0] regWrData,
  input wire logic [7:0] regRdData
);
  initial begin
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    regAddr = 7'h00;
    regWrData = 8'h00;
  end

  // Released lines show the inverse, so stale values never look valid
  task automatic wr(input logic [6:0] addr, input logic [7:0] data);
    @(negedge clk_sys);
    regAddr = addr;
    regWrData = data;
    regWrEn = 1'b1;
    @(negedge clk_sys);
    regWrEn = 1'b0;
    regAddr = ~addr;
    regWrData = ~data;
  endtask

  task automatic rd(input logic [6:0] addr, output logic [7:0] data);
    @(negedge clk_sys);
    regAddr = addr;
    regRdEn = 1'b1;
    @(negedge clk_sys);
    regRdEn = 1'b0;
    regAddr = ~addr;
    data = regRdData;
  endtask
endmodule // sfw_host_model

// file: verif/test_synth_frequency_word_control.sv
// Self-checking bench of the frequency-word control with shortened tuning phases.
// Assumes the host model drives the register port; mode inputs come from here.
`timescale 1ns/1ns
module test_synth_frequency_word_control;
  import sfw_pkg::*;
  localparam int CAL = 6;
  localparam int SETTLE = 8;
  logic clk_sys, nrst, regWrEn, regRdEn, txPacketBusy, modEnable, txData;
  logic pllEnable, vcoCalActive, synthReady, txEnable, rxEnable, highBand;
  logic [6:0] regAddr, intRatio;
  logic [7:0] regWrData, regRdData, divRatio, d;
  logic [8:0] deviationWord;
  logic [15:0] fracWord;
  sfw_mode_t modeReq;
  int fails = 0;
  int total_checks = 0;
  int cycles = 0;

  sfw_freq_control #(.BIAS_CYCLES(4), .CAL_CYCLES(CAL), .SETTLE_CYCLES(SETTLE),
    .TOTAL_CYCLES(40)) i_sfw_freq_control (.clk_sys(clk_sys), .nrst(nrst),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData),
    .regRdData(regRdData), .modeReq(modeReq), .txPacketBusy(txPacketBusy),
    .modEnable(modEnable), .txData(txData), .deviationWord(deviationWord),
    .pllEnable(pllEnable), .vcoCalActive(vcoCalActive), .synthReady(synthReady),
    .txEnable(txEnable), .rxEnable(rxEnable), .highBand(highBand), .intRatio(intRatio),
    .fracWord(fracWord), .divRatio(divRatio));
  sfw_host_model i_sfw_host_model (.clk_sys(clk_sys), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData));

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Whole run needs a few hundred cycles
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      summarize();
    end
  end

  task automatic waitLock();
    int n;
    n = 0;
    while (vcoCalActive !== 1'b1 && n < 80) begin
      @(negedge clk_sys);
      n++;
    end
    chk("calibration start", vcoCalActive, 1'b1);
    n = 0;
    while (synthReady !== 1'b1 && n < 80) begin
      @(negedge clk_sys);
      n++;
    end
    chk("tune within budget", n <= CAL + SETTLE + 2, 1'b1);
    repeat (3) @(negedge clk_sys);
  endtask

  task automatic scnReset();
    logic [6:0] addrs [7] = '{7'h73, 7'h74, 7'h75, 7'h76, 7'h77, 7'h79, 7'h7A};
    logic [7:0] vals [7] = '{8'h00, 8'h00, 8'h35, 8'hBB, 8'h80, 8'h00, 8'h00};
    waitLock();
    chk("int ratio", intRatio, 7'h2D);
    chk("frac word", fracWord, 16'hBB80);
    chk("high band", highBand, 1'b1);
    chk("pll on in tune", pllEnable, 1'b1);
    for (int i = 0; i < 7; i++) begin
      i_sfw_host_model.rd(addrs[i], d);
      chk("reset value", d, vals[i]);
    end
    i_sfw_host_model.rd(7'h78, d);
    chk("unmapped read", d, 8'h00);
  endtask

  task automatic scnBand();
    i_sfw_host_model.wr(7'h75, 8'h1F);
    i_sfw_host_model.rd(7'h75, d);
    chk("band clamp", d, 8'h17);
    waitLock();
    chk("int ratio top", intRatio, 7'h2F);
    chk("low band", highBand, 1'b0);
  endtask

  // Lone first bytes must not move the frequency
  task automatic scnPairs();
    i_sfw_host_model.wr(7'h76, 8'h00);
    repeat (30) @(negedge clk_sys);
    chk("carrier staged", fracWord, 16'hBB80);
    i_sfw_host_model.wr(7'h77, 8'h10);
    waitLock();
    chk("carrier word", fracWord, 16'h0010);
    i_sfw_host_model.wr(7'h73, 8'hFF);
    repeat (30) @(negedge clk_sys);
    chk("offset staged", fracWord, 16'h0010);
    i_sfw_host_model.wr(7'h74, 8'h03);
    waitLock();
    chk("signed offset", fracWord, 16'h000F);
  endtask

  task automatic scnHop();
    i_sfw_host_model.wr(7'h7A, 8'h01);
    waitLock();
    i_sfw_host_model.wr(7'h79, 8'h05);
    waitLock();
    chk("hop carrier", fracWord, 16'h014F);
  endtask

  task automatic scnTxRx();
    logic ok;
    modeReq = MODE_TX;
    repeat (20) @(negedge clk_sys);
    chk("tx entered", txEnable, 1'b1);
    chk("tx frequency", fracWord, 16'h014F);
    modEnable = 1'b1;
    txData = 1'b1;
    repeat (4) @(negedge clk_sys);
    chk("deviation up", fracWord, 16'h015F);
    txData = 1'b0;
    repeat (4) @(negedge clk_sys);
    chk("deviation down", fracWord, 16'h013F);
    modEnable = 1'b0;
    modeReq = MODE_RX;
    waitLock();
    chk("rx entered", rxEnable, 1'b1);
    chk("if shift int", intRatio, 7'h2E);
    chk("if shift frac", fracWord, 16'hE3DF);
    // Same channel rewritten in receive still retunes
    i_sfw_host_model.wr(7'h79, 8'h05);
    waitLock();
    chk("rx resumed", rxEnable, 1'b1);
    chk("rx hop frac", fracWord, 16'hE3DF);
    ok = 1'b1;
    repeat (60) begin
      @(negedge clk_sys);
      if (divRatio < intRatio - 3 || divRatio > intRatio + 4) ok = 1'b0;
    end
    chk("modulator range", ok, 1'b1);
  endtask

  // Hop during a packet waits for the packet end
  task automatic scnBusy();
    logic bad;
    modeReq = MODE_TX;
    waitLock();
    txPacketBusy = 1'b1;
    i_sfw_host_model.wr(7'h79, 8'h06);
    bad = 1'b0;
    repeat (40) begin
      @(negedge clk_sys);
      if (vcoCalActive !== 1'b0 || txEnable !== 1'b1) bad = 1'b1;
    end
    chk("no retune in packet", bad, 1'b0);
    txPacketBusy = 1'b0;
    waitLock();
    chk("tx resumed", txEnable, 1'b1);
    chk("deferred hop", fracWord, 16'h018F);
    modeReq = MODE_READY;
    repeat (4) @(negedge clk_sys);
    chk("ready pll off", pllEnable, 1'b0);
    chk("ready not locked", synthReady, 1'b0);
  endtask

  initial begin
    nrst = 1'b0;
    modeReq = MODE_TUNE;
    txPacketBusy = 1'b0;
    modEnable = 1'b0;
    txData = 1'b0;
    deviationWord = 9'h004;
    repeat (3) @(negedge clk_sys);
    nrst = 1'b1;
    scnReset();
    scnBand();
    scnPairs();
    scnHop();
    scnTxRx();
    scnBusy();
    summarize();
  end
endmodule // test_synth_frequency_word_control

// file: verilog/sfw_delta_sigma.sv
// Third-order cascaded delta-sigma modulator with modulo-64000 accumulators.
// Assumes ratio words come from flip-flops; steps once per 10 MHz reference tick.
`timescale 1ns/1ns
module sfw_delta_sigma (
  input wire logic clk_sys,
  input wire logic nrst,
  sfw_mod_if.dsm mif
);
  import sfw_pkg::*;

  typedef struct packed {
    logic [4:0] tickCnt;
    logic [15:0] acc1;
    logic [15:0] acc2;
    logic [15:0] acc3;
    logic c2d;
    logic c3d;
    logic c3dd;
    logic [7:0] divRatio;
  } sfw_dsm_t;

  sfw_dsm_t st;
  sfw_dsm_t next_st;
  logic refTick;
  logic [16:0] sum1;
  logic [16:0] sum2;
  logic [16:0] sum3;
  logic c1;
  logic c2;
  logic c3;
  logic signed [8:0] noise;

  assign refTick = (st.tickCnt == 5'(REF_TICK_CYCLES - 1));
  // Wrap at 64000, not at a power of two
  assign sum1 = {1'b0, st.acc1} + {1'b0, mif.fracWord};
  assign c1 = (sum1 >= FRAC_MODULUS);
  assign sum2 = {1'b0, st.acc2} + (c1 ? sum1 - FRAC_MODULUS : sum1);
  assign c2 = (sum2 >= FRAC_MODULUS);
  assign sum3 = {1'b0, st.acc3} + (c2 ? sum2 - FRAC_MODULUS : sum2);
  assign c3 = (sum3 >= FRAC_MODULUS);
  assign noise = $signed({8'h00, c1}) + $signed({8'h00, c2}) - $signed({8'h00, st.c2d})
    + $signed({8'h00, c3}) - $signed({7'h00, st.c3d, 1'b0}) + $signed({8'h00, st.c3dd});

  always_comb begin
    next_st = st;
    next_st.tickCnt = refTick ? 5'h00 : st.tickCnt + 5'h01;
    if (refTick) begin
      next_st.acc1 = 16'(c1 ? sum1 - FRAC_MODULUS : sum1);
      next_st.acc2 = 16'(c2 ? sum2 - FRAC_MODULUS : sum2);
      next_st.acc3 = 16'(c3 ? sum3 - FRAC_MODULUS : sum3);
      next_st.c2d = c2;
      next_st.c3d = c3;
      next_st.c3dd = st.c3d;
      next_st.divRatio = 8'($signed({2'b00, mif.intRatio}) + noise);
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign mif.divRatio = st.divRatio;

  a_acc_wrap: assert property (@(posedge clk_sys) disable iff (!nrst)
    {1'b0, st.acc1} < FRAC_MODULUS && {1'b0, st.acc3} < FRAC_MODULUS)
    else $error("accumulator outside modulus");

  a_ratio_spread: assert property (@(posedge clk_sys) disable iff (!nrst)
    refTick && $stable(mif.intRatio) |=> st.divRatio + 8'h03 >= {1'b0, $past(mif.intRatio)}
      && st.divRatio <= {1'b0, $past(mif.intRatio)} + 8'h04)
    else $error("division ratio outside modulator range");

endmodule // sfw_delta_sigma

// file: verilog/sfw_freq_control.sv
// Frequency-word registers, retune sequencer and ratio builder of the synthesizer.
// Assumes register strobes are decoded from the serial port, synchronous to clk_sys.
`timescale 1ns/1ns

// Overview of operation
// - Fractional ratio is shaped by a third-order modulo-64000 modulator at 10 MHz.
// - Integer ratio equals the band index plus 24, moved by any carry or borrow of the fraction.
// - Stored band index and carrier word feed the ratio, carrier counting 1/64000.
// - Half-rate band bit selects the output divide-by-two, high band when set.
// - Band index writes above 23 are stored as 23.
// - Fraction combines carrier word, offset word and deviation word.
// - FSK shifts the fraction per transmitted data bit inside the loop.
// - Receive lowers the synthesizer by 937.5 kHz without register change.
// - Same channel serves transmit and receive with no host reprogramming.
// - Hop step counts in 10 kHz units, at most 2.55 MHz.
// - Carrier equals nominal plus channel index times step times 10 kHz.
// - Every frequency change and power-up starts a VCO calibration.
// - Loop settles 100 us; bias, calibration and settling end within 200 us.
// - Writing only the wanted mode walks through every needed step.
// - Hop writes in transmit or receive retune then resume; busy packets finish first.
// - Offset word is signed, 156.25 Hz times one plus the half-rate bit.
// - Deviation is the nine-bit word times 625 Hz in either band.
module sfw_freq_control #(
  parameter int BIAS_CYCLES = sfw_pkg::BIAS_SETTLE_CYCLES,
  parameter int CAL_CYCLES = sfw_pkg::VCO_CAL_CYCLES,
  parameter int SETTLE_CYCLES = sfw_pkg::LOOP_SETTLE_CYCLES,
  parameter int TOTAL_CYCLES = sfw_pkg::TUNE_TOTAL_CYCLES
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [6:0] regAddr,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  input wire sfw_pkg::sfw_mode_t modeReq,
  input wire logic txPacketBusy,
  input wire logic modEnable,
  input wire logic txData,
  input wire logic [8:0] deviationWord,
  output logic pllEnable,
  output logic vcoCalActive,
  output logic synthReady,
  output logic txEnable,
  output logic rxEnable,
  output logic highBand,
  output logic [6:0] intRatio,
  output logic [15:0] fracWord,
  output logic [7:0] divRatio
);
  import sfw_pkg::*;

  typedef enum logic [7:0] {
    S_IDLE = 8'h01,
    S_CALC = 8'h02,
    S_BIAS = 8'h04,
    S_CAL = 8'h08,
    S_SETTLE = 8'h10,
    S_TUNE = 8'h20,
    S_TX = 8'h40,
    S_RX = 8'h80
  } sfw_seq_t;

  typedef struct packed {
    sfw_seq_t seq;
    logic [9:0] offsetWord;
    logic [7:0] offsetLowStage;
    logic [7:0] bandReg;
    logic [15:0] carrierWord;
    logic [7:0] carrierHighStage;
    logic [7:0] hopChannel;
    logic [7:0] hopStep;
    logic retunePending;
    logic rxTuned;
    logic [19:0] timer;
    logic [2:0] divStep;
    logic [23:0] rem;
    logic [6:0] quot;
    logic [6:0] intBase;
    logic [15:0] fracBase;
    logic [6:0] outInt;
    logic [15:0] outFrac;
    logic [7:0] rdData;
  } sfw_ctrl_t;

  sfw_ctrl_t st;
  sfw_ctrl_t next_st;
  sfw_mod_if mif ();

  logic hb;
  logic [4:0] bandIndex;
  logic rxTarget;
  logic [15:0] hopProd;
  logic [23:0] hopUnits;
  logic [23:0] ifUnits;
  logic [23:0] offsetUnits;
  logic [23:0] totalBiased;
  logic [23:0] divisor;
  logic [17:0] devMag;
  logic signed [17:0] devApplied;
  logic signed [17:0] devFrac;
  logic freqWrite;
  logic wantRetune;
  logic needCalc;

  assign hb = st.bandReg[BAND_HB_BIT];
  assign bandIndex = st.bandReg[BAND_INDEX_MSB:0];
  assign rxTarget = (modeReq == MODE_RX);

  // Channel times step, in fractional units of the current band
  assign hopProd = st.hopChannel * st.hopStep;
  assign hopUnits = 24'(hopProd) << (hb ? HOP_UNIT_SHIFT - 1 : HOP_UNIT_SHIFT);
  // IF shift is fixed in Hz, so it halves in units when the band doubles
  assign ifUnits = rxTarget ? 24'(IF_SHIFT_UNITS >> hb) : 24'h00_0000;
  assign offsetUnits = {{14{st.offsetWord[9]}}, st.offsetWord};
  // One modulus of bias keeps the sum positive when offset and IF pull below N=24
  assign totalBiased = 24'(bandIndex) * 24'(FRAC_MODULUS) + 24'(st.carrierWord)
    + offsetUnits + hopUnits - ifUnits + 24'(FRAC_MODULUS);
  assign divisor = 24'(FRAC_MODULUS) << st.divStep;

  // Deviation is 625 Hz per step in both bands, so its unit count halves in high band
  assign devMag = 18'(deviationWord) << (hb ? DEV_UNIT_SHIFT - 1 : DEV_UNIT_SHIFT);
  assign devApplied = (st.seq == S_TX && modEnable)
    ? (txData ? $signed(devMag) : -$signed(devMag)) : 18'sh0_0000;
  assign devFrac = $signed({2'b00, st.fracBase}) + devApplied;

  assign freqWrite = regWrEn && (regAddr == ADDR_OFFSET_HIGH || regAddr == ADDR_BAND_SELECT
    || regAddr == ADDR_CARRIER_LOW || regAddr == ADDR_HOP_CHANNEL
    || regAddr == ADDR_HOP_STEP);
  // A busy transmit packet keeps its frequency until it ends
  assign wantRetune = st.retunePending && !(st.seq == S_TX && txPacketBusy);
  // Receive needs the IF-shifted word, transmit and tune the plain one
  assign needCalc = wantRetune || (rxTarget != st.rxTuned && !(st.seq == S_TX && txPacketBusy));

  always_comb begin
    next_st = st;
    // Register writes
    if (regWrEn) begin
      unique case (regAddr)
        ADDR_OFFSET_LOW: next_st.offsetLowStage = regWrData;
        ADDR_OFFSET_HIGH: next_st.offsetWord = {regWrData[OFFSET_HIGH_MSB:0], st.offsetLowStage};
        ADDR_BAND_SELECT: begin
          next_st.bandReg = {1'b0, regWrData[BAND_SB_BIT:BAND_HB_BIT],
            (regWrData[BAND_INDEX_MSB:0] > BAND_INDEX_MAX) ? BAND_INDEX_MAX
            : regWrData[BAND_INDEX_MSB:0]};
        end
        ADDR_CARRIER_HIGH: next_st.carrierHighStage = regWrData;
        ADDR_CARRIER_LOW: next_st.carrierWord = {st.carrierHighStage, regWrData};
        ADDR_HOP_CHANNEL: next_st.hopChannel = regWrData;
        ADDR_HOP_STEP: next_st.hopStep = regWrData;
        default: begin
        end
      endcase
    end
    // Register reads; staged low offset byte and high carrier byte read back as written
    if (regRdEn) begin
      unique case (regAddr)
        ADDR_OFFSET_LOW: next_st.rdData = st.offsetLowStage;
        ADDR_OFFSET_HIGH: next_st.rdData = {6'h00, st.offsetWord[9:8]};
        ADDR_BAND_SELECT: next_st.rdData = st.bandReg;
        ADDR_CARRIER_HIGH: next_st.rdData = st.carrierHighStage;
        ADDR_CARRIER_LOW: next_st.rdData = st.carrierWord[7:0];
        ADDR_HOP_CHANNEL: next_st.rdData = st.hopChannel;
        ADDR_HOP_STEP: next_st.rdData = st.hopStep;
        default: next_st.rdData = 8'h00;
      endcase
    end

    // Sequencer
    if (st.timer != 20'h0_0000) begin
      next_st.timer = st.timer - 20'h0_0001;
    end
    unique case (st.seq)
      S_IDLE: begin
        if (st.retunePending || modeReq != MODE_READY) begin
          next_st.seq = S_CALC;
        end
      end
      S_CALC: begin
        if (st.rem >= divisor) begin
          next_st.rem = st.rem - divisor;
          next_st.quot[st.divStep] = 1'b1;
        end
        if (st.divStep == 3'h0) begin
          next_st.seq = S_BIAS;
          next_st.timer = 20'(BIAS_CYCLES - 1);
        end else begin
          next_st.divStep = st.divStep - 3'h1;
        end
      end
      S_BIAS: begin
        if (st.timer == 20'h0_0000) begin
          next_st.seq = S_CAL;
          next_st.timer = 20'(CAL_CYCLES - 1);
        end
      end
      S_CAL: begin
        if (st.timer == 20'h0_0000) begin
          next_st.seq = S_SETTLE;
          next_st.timer = 20'(SETTLE_CYCLES - 1);
        end
      end
      S_SETTLE, S_TUNE, S_TX, S_RX: begin
        if (st.seq == S_SETTLE && st.timer != 20'h0_0000) begin
          next_st.seq = S_SETTLE;
        end else if (needCalc && modeReq != MODE_READY) begin
          next_st.seq = S_CALC;
        end else if (st.seq == S_TX && txPacketBusy) begin
          next_st.seq = S_TX;
        end else begin
          unique case (modeReq)
            MODE_READY: next_st.seq = st.retunePending ? S_CALC : S_IDLE;
            MODE_TUNE: next_st.seq = S_TUNE;
            MODE_TX: next_st.seq = S_TX;
            MODE_RX: next_st.seq = S_RX;
          endcase
        end
      end
    endcase
    // Entry into a new calculation snapshots the target word
    if (next_st.seq == S_CALC && st.seq != S_CALC) begin
      next_st.rem = totalBiased;
      next_st.quot = 7'h00;
      next_st.divStep = 3'h6;
      next_st.rxTuned = rxTarget;
      next_st.retunePending = 1'b0;
    end
    if (st.seq == S_CALC && st.divStep == 3'h0) begin
      // Bias of one modulus is taken back by basing on 23, not 24
      next_st.intBase = INT_RATIO_BASE - 7'h01 + next_st.quot;
      next_st.fracBase = 16'(next_st.rem);
    end
    // A write in the same cycle as a capture still leaves a pending retune
    if (freqWrite) begin
      next_st.retunePending = 1'b1;
    end

    // Output ratio with the live deviation folded in; one wrap is enough
    if (devFrac < 18'sh0_0000) begin
      next_st.outFrac = 16'(devFrac + $signed({1'b0, FRAC_MODULUS}));
      next_st.outInt = st.intBase - 7'h01;
    end else if (devFrac >= $signed({1'b0, FRAC_MODULUS})) begin
      next_st.outFrac = 16'(devFrac - $signed({1'b0, FRAC_MODULUS}));
      next_st.outInt = st.intBase + 7'h01;
    end else begin
      next_st.outFrac = 16'(devFrac);
      next_st.outInt = st.intBase;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st.seq <= S_IDLE;
      st.offsetWord <= {RST_OFFSET_HIGH[OFFSET_HIGH_MSB:0], RST_OFFSET_LOW};
      st.offsetLowStage <= RST_OFFSET_LOW;
      st.bandReg <= RST_BAND_SELECT;
      st.carrierWord <= {RST_CARRIER_HIGH, RST_CARRIER_LOW};
      st.carrierHighStage <= RST_CARRIER_HIGH;
      st.hopChannel <= RST_HOP_CHANNEL;
      st.hopStep <= RST_HOP_STEP;
      st.retunePending <= 1'b1;
      st.rxTuned <= 1'b0;
      st.timer <= 20'h0_0000;
      st.divStep <= 3'h0;
      st.rem <= 24'h00_0000;
      st.quot <= 7'h00;
      st.intBase <= INT_RATIO_BASE;
      st.fracBase <= 16'h0000;
      st.outInt <= INT_RATIO_BASE;
      st.outFrac <= 16'h0000;
      st.rdData <= 8'h00;
    end else begin
      st <= next_st;
    end
  end

  assign mif.intRatio = st.outInt;
  assign mif.fracWord = st.outFrac;

  sfw_delta_sigma u_dsm (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .mif(mif)
  );

  assign regRdData = st.rdData;
  assign pllEnable = (st.seq != S_IDLE);
  assign vcoCalActive = (st.seq == S_CAL);
  assign synthReady = (st.seq == S_TUNE || st.seq == S_TX || st.seq == S_RX);
  assign txEnable = (st.seq == S_TX);
  assign rxEnable = (st.seq == S_RX);
  // Output divide-by-two stays in when clear
  assign highBand = hb;
  assign intRatio = st.outInt;
  assign fracWord = st.outFrac;
  assign divRatio = mif.divRatio;

  // Cycles spent from the end of calculation to lock
  logic [19:0] tuneCount;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      tuneCount <= 20'h0_0000;
    end else if (st.seq == S_CALC) begin
      tuneCount <= 20'h0_0000;
    end else if (st.seq == S_BIAS || st.seq == S_CAL || st.seq == S_SETTLE) begin
      tuneCount <= tuneCount + 20'h0_0001;
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  sequence s_calc_done;
    st.seq == S_CALC && st.divStep == 3'h0;
  endsequence

  sequence s_bias_entry;
    st.seq == S_BIAS && st.timer == 20'(BIAS_CYCLES - 1);
  endsequence

  a_band_clamp: assert property (
    regWrEn && regAddr == ADDR_BAND_SELECT && regWrData[4:0] > BAND_INDEX_MAX
    |=> st.bandReg[4:0] == BAND_INDEX_MAX)
    else $error("band index not limited to 23");

  a_cal_follows: assert property (s_calc_done |=> s_bias_entry)
    else $error("calculation not followed by bias settle");

  a_lock_bound: assert property (
    $rose(synthReady) |-> tuneCount >= 20'(SETTLE_CYCLES) && tuneCount <= 20'(TOTAL_CYCLES))
    else $error("tuning outside settle window");

  a_int_direct: assert property (
    st.seq == S_TUNE && st.hopChannel == 8'h00 && st.offsetWord == 10'h000
    && st.carrierWord < FRAC_MODULUS[15:0] && !st.rxTuned && $stable(st.bandReg)
    && $stable(st.carrierWord) && !st.retunePending
    |-> st.intBase == INT_RATIO_BASE + 7'(bandIndex) && st.fracBase == st.carrierWord)
    else $error("integer or fraction not taken from registers");

  a_rx_shifted: assert property (rxEnable |-> st.rxTuned)
    else $error("receive entered without IF shift");

  a_hop_retune: assert property (
    rxEnable && regWrEn && regAddr == ADDR_HOP_CHANNEL && modeReq == MODE_RX
    |=> ##1 st.seq == S_CALC)
    else $error("hop write in receive did not retune");

  a_tx_defer: assert property (
    txEnable && txPacketBusy |=> txEnable)
    else $error("busy transmit packet interrupted");

  a_pair_hold: assert property (
    regWrEn && (regAddr == ADDR_OFFSET_LOW || regAddr == ADDR_CARRIER_HIGH)
    |=> $stable(st.offsetWord) && $stable(st.carrierWord))
    else $error("half-written pair reached the synthesizer");

  a_fsk_shift: assert property (
    txEnable && modEnable && !txData && $stable(st.fracBase)
    // Fraction at least the deviation, so no wrap into the integer
    && {2'b00, st.fracBase} >= devMag
    |=> st.outFrac == 16'($past(st.fracBase) - 16'($past(devMag))))
    else $error("deviation not applied for data bit");

endmodule // sfw_freq_control
